// *** rtl/acf_pkg.sv ***
package acf_pkg;

	// ==========================================================
	// Register indexes (word addresses on the plain port)
	localparam int ACF_AW = 2;
	localparam logic [1:0] ACF_IDX_CLK_SEL = 2'h0;
	localparam logic [1:0] ACF_IDX_RES_HI = 2'h1;
	localparam logic [1:0] ACF_IDX_RES_LO = 2'h2;
	localparam logic [1:0] ACF_IDX_FMT = 2'h3;

	// ==========================================================
	// Field positions and reset values
	localparam int ACF_SEL_LSB = 4;
	localparam int ACF_SEL_W = 3;
	localparam int ACF_FMT_BIT = 0;
	localparam int ACF_RC_BIT = 1;
	localparam int ACF_RES_W = 10;
	localparam logic [2:0] ACF_CLK_SEL_RST = 3'h0;
	localparam logic [7:0] ACF_RES_RST = 8'h00;
	localparam logic ACF_FMT_RST = 1'b0;

	// ==========================================================
	// Conversion clock select codes
	localparam logic [2:0] ACF_SEL_DIV2 = 3'h0;
	localparam logic [2:0] ACF_SEL_DIV8 = 3'h1;
	localparam logic [2:0] ACF_SEL_DIV32 = 3'h2;
	localparam logic [2:0] ACF_SEL_DIV4 = 3'h4;
	localparam logic [2:0] ACF_SEL_DIV16 = 3'h5;
	localparam logic [2:0] ACF_SEL_DIV64 = 3'h6;
	localparam logic [1:0] ACF_RC_CODE = 2'h3;

	// ==========================================================
	// Timing: core clock and dedicated RC clock ceiling
	localparam int ACF_CORE_CLK_KHZ = 10000;
	localparam int ACF_RC_MAX_KHZ = 500;
	// Least RC period rounds up to whole core cycles
	localparam int ACF_RC_DIV_CYC =
		(ACF_CORE_CLK_KHZ + ACF_RC_MAX_KHZ - 1) / ACF_RC_MAX_KHZ;

	// ==========================================================
	// Bus request and result register pair
	typedef struct packed {
		logic [1:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} acf_bus_req_t;

	typedef struct packed {
		logic [7:0] hi;
		logic [7:0] lo;
	} acf_res_pair_t;

	// Core cycles per conversion clock period for a select code
	function automatic logic [7:0] acf_period(input logic [2:0] sel);
		logic [7:0] p;
		p = 8'h00;
		if (sel[1:0] == ACF_RC_CODE) begin
			p = 8'(ACF_RC_DIV_CYC);
		end else begin
			case (sel)
				ACF_SEL_DIV2: p = 8'h02;
				ACF_SEL_DIV8: p = 8'h08;
				ACF_SEL_DIV32: p = 8'h20;
				ACF_SEL_DIV4: p = 8'h04;
				ACF_SEL_DIV16: p = 8'h10;
				ACF_SEL_DIV64: p = 8'h40;
				default: p = 8'(ACF_RC_DIV_CYC);
			endcase
		end
		return p;
	endfunction

endpackage

// *** rtl/acf_clk_div.sv ***
`timescale 1ns/1ns
module acf_clk_div #(
	parameter int CW = 8
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Conversion clock select
	input wire logic [2:0] sel,
	// Conversion clock enable pulse
	output logic tick
);
	import acf_pkg::*;

	logic [CW-1:0] div_cnt_r, div_cnt_nxt;
	logic [CW-1:0] rc_cnt_r, rc_cnt_nxt;
	logic [2:0] sel_r, sel_nxt;
	logic tick_r, tick_nxt;
	logic rc_on;
	logic sel_chg;

	// ==========================================================
	// Next state: oscillator divider and free running RC divider
	always_comb begin
		rc_on = (sel[1:0] == ACF_RC_CODE);
		sel_chg = (sel != sel_r);
		sel_nxt = sel;
		// Reload from the selected divisor; restart on a new select
		if (div_cnt_r == '0 || sel_chg) begin
			div_cnt_nxt = CW'(acf_period(sel) - 8'h01);
		end else begin
			div_cnt_nxt = div_cnt_r - 1'b1;
		end
		if (rc_cnt_r == '0) begin
			rc_cnt_nxt = CW'(ACF_RC_DIV_CYC - 1);
		end else begin
			rc_cnt_nxt = rc_cnt_r - 1'b1;
		end
		// RC selection takes over from the divided oscillator
		if (rc_on) begin
			tick_nxt = (rc_cnt_r == '0);
		end else begin
			tick_nxt = (div_cnt_r == '0) && !sel_chg;
		end
	end

	// Registers
	always_ff @(posedge core_clk) begin
		if (rst) begin
			div_cnt_r <= '0;
			rc_cnt_r <= '0;
			sel_r <= ACF_CLK_SEL_RST;
			tick_r <= 1'b0;
		end else begin
			div_cnt_r <= div_cnt_nxt;
			rc_cnt_r <= rc_cnt_nxt;
			sel_r <= sel_nxt;
			tick_r <= tick_nxt;
		end
	end

	assign tick = tick_r;

endmodule

// *** rtl/acf_res_fmt.sv ***
`timescale 1ns/1ns
module acf_res_fmt (
	// Raw result and layout choice
	input wire logic [9:0] res,
	input wire logic right_just,
	// Register images
	output acf_pkg::acf_res_pair_t pair
);
	import acf_pkg::*;

	// ==========================================================
	// Place the ten bits left or right justified
	always_comb begin
		if (right_just) begin
			pair.hi = {6'h00, res[9:8]};
			pair.lo = res[7:0];
		end else begin
			pair.hi = res[9:2];
			pair.lo = {res[1:0], 6'h00};
		end
	end

endmodule

// *** rtl/acf_adc_clk_fmt.sv ***
// Our own choices: strobed register access and the address map.
`timescale 1ns/1ns
module acf_adc_clk_fmt (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Register port
	input acf_pkg::acf_bus_req_t bus_req,
	output logic [7:0] rd_data,
	// Converter side
	input wire logic conv_done,
	input wire logic [9:0] conv_result,
	output logic conv_tick
);
	import acf_pkg::*;

	// ==========================================================
	// Register state
	logic [2:0] clk_sel_r, clk_sel_nxt;
	logic fmt_r, fmt_nxt;
	logic [7:0] res_hi_r, res_hi_nxt;
	logic [7:0] res_lo_r, res_lo_nxt;
	logic [7:0] rd_data_r, rd_data_nxt;
	acf_res_pair_t pair;
	logic wr_sel, wr_hi, wr_lo, wr_fmt;
	logic rc_active;

	// ==========================================================
	// Conversion clock generation
	acf_clk_div #(
		.CW(8)
	) u_div (
		.core_clk(core_clk),
		.rst(rst),
		.sel(clk_sel_r),
		.tick(conv_tick)
	);

	// ==========================================================
	// Result layout
	acf_res_fmt u_fmt (
		.res(conv_result),
		.right_just(fmt_r),
		.pair(pair)
	);

	// Write decode
	assign wr_sel = bus_req.wr && (bus_req.addr == ACF_IDX_CLK_SEL);
	assign wr_hi = bus_req.wr && (bus_req.addr == ACF_IDX_RES_HI);
	assign wr_lo = bus_req.wr && (bus_req.addr == ACF_IDX_RES_LO);
	assign wr_fmt = bus_req.wr && (bus_req.addr == ACF_IDX_FMT);
	assign rc_active = (clk_sel_r[1:0] == ACF_RC_CODE);

	// ==========================================================
	// Next register values
	always_comb begin
		clk_sel_nxt = clk_sel_r;
		fmt_nxt = fmt_r;
		res_hi_nxt = res_hi_r;
		res_lo_nxt = res_lo_r;
		// Only the three select bits store; the rest drop
		if (wr_sel) begin
			clk_sel_nxt = bus_req.wdata[ACF_SEL_LSB +: ACF_SEL_W];
		end
		if (wr_fmt) begin
			fmt_nxt = bus_req.wdata[ACF_FMT_BIT];
		end
		if (wr_hi) begin
			res_hi_nxt = bus_req.wdata;
		end
		if (wr_lo) begin
			res_lo_nxt = bus_req.wdata;
		end
		// Completion wins over a software write in the same cycle
		if (conv_done) begin
			res_hi_nxt = pair.hi;
			res_lo_nxt = pair.lo;
		end
	end

	// Registers
	always_ff @(posedge core_clk) begin
		if (rst) begin
			clk_sel_r <= ACF_CLK_SEL_RST;
			fmt_r <= ACF_FMT_RST;
			res_hi_r <= ACF_RES_RST;
			res_lo_r <= ACF_RES_RST;
		end else begin
			clk_sel_r <= clk_sel_nxt;
			fmt_r <= fmt_nxt;
			res_hi_r <= res_hi_nxt;
			res_lo_r <= res_lo_nxt;
		end
	end

	// ==========================================================
	// Read data, valid only in the cycle after the strobe
	always_comb begin
		rd_data_nxt = 8'h00;
		if (bus_req.rd) begin
			case (bus_req.addr)
				ACF_IDX_CLK_SEL: begin
					rd_data_nxt = 8'(clk_sel_r) << ACF_SEL_LSB;
				end
				ACF_IDX_RES_HI: begin
					rd_data_nxt = res_hi_r;
				end
				ACF_IDX_RES_LO: begin
					rd_data_nxt = res_lo_r;
				end
				ACF_IDX_FMT: begin
					rd_data_nxt[ACF_FMT_BIT] = fmt_r;
					rd_data_nxt[ACF_RC_BIT] = rc_active;
				end
				default: begin
					rd_data_nxt = 8'h00;
				end
			endcase
		end
	end

	// Read register
	always_ff @(posedge core_clk) begin
		if (rst) begin
			rd_data_r <= 8'h00;
		end else begin
			rd_data_r <= rd_data_nxt;
		end
	end

	assign rd_data = rd_data_r;

	// ==========================================================
	// Helper: spacing of conversion clock pulses
	logic [7:0] gap_r, gap_nxt;
	logic [1:0] seen_r, seen_nxt;
	logic [7:0] exp_gap;

	always_comb begin
		exp_gap = acf_period(clk_sel_r) - 8'h01;
		gap_nxt = conv_tick ? 8'h00 : gap_r + 8'h01;
		seen_nxt = seen_r;
		if (wr_sel) begin
			seen_nxt = 2'h0;
		end else if (conv_tick && seen_r != 2'h3) begin
			seen_nxt = seen_r + 2'h1;
		end
	end

	// Helper registers
	always_ff @(posedge core_clk) begin
		if (rst) begin
			gap_r <= 8'h00;
			seen_r <= 2'h0;
		end else begin
			gap_r <= gap_nxt;
			seen_r <= seen_nxt;
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	sequence s_sel_read;
		bus_req.rd && (bus_req.addr == ACF_IDX_CLK_SEL);
	endsequence

	sequence s_done_left;
		conv_done && !fmt_r;
	endsequence

	sequence s_done_right;
		conv_done && fmt_r;
	endsequence

	a_sel_rsv_zero: assert property (
		s_sel_read |=> (rd_data[7] == 1'b0) && (rd_data[3:0] == 4'h0)
			&& (rd_data[6:4] == $past(clk_sel_r)))
		else $error("clock select reserved bits not zero");

	a_sel_wr_take: assert property (
		(bus_req.wr && bus_req.addr == ACF_IDX_CLK_SEL)
			|=> clk_sel_r == $past(bus_req.wdata[6:4]))
		else $error("clock select write not taken");

	a_tick_period: assert property (
		(conv_tick && seen_r == 2'h3 && !wr_sel) |-> gap_r == exp_gap)
		else $error("conversion clock period wrong");

	a_rc_period: assert property (
		(conv_tick && rc_active && seen_r == 2'h3)
			|-> gap_r == 8'(ACF_RC_DIV_CYC - 1))
		else $error("rc clock period wrong");

	a_left_high: assert property (
		s_done_left |=> res_hi_r == $past(conv_result[9:2]))
		else $error("left justified high byte wrong");

	a_left_low: assert property (
		s_done_left |=> res_lo_r[7:6] == $past(conv_result[1:0]))
		else $error("left justified low bits wrong");

	a_right_high: assert property (
		s_done_right |=> res_hi_r[1:0] == $past(conv_result[9:8]))
		else $error("right justified high bits wrong");

	a_right_low: assert property (
		s_done_right |=> res_lo_r == $past(conv_result[7:0]))
		else $error("right justified low byte wrong");

	a_done_both: assert property (
		conv_done |=> ($past(fmt_r) ? {res_hi_r[1:0], res_lo_r}
			: {res_hi_r, res_lo_r[7:6]}) == $past(conv_result))
		else $error("result registers not both loaded");

	a_res_readback: assert property (
		(conv_done ##1 (bus_req.rd && bus_req.addr == ACF_IDX_RES_HI && !conv_done
			&& !bus_req.wr)) |=> rd_data == $past(res_hi_r))
		else $error("result high readback wrong");

	// ==========================================================
	// Register port reads and writes
	sequence s_hi_read;
		bus_req.rd && (bus_req.addr == ACF_IDX_RES_HI);
	endsequence

	sequence s_lo_read;
		bus_req.rd && (bus_req.addr == ACF_IDX_RES_LO);
	endsequence

	sequence s_fmt_read;
		bus_req.rd && (bus_req.addr == ACF_IDX_FMT);
	endsequence

	sequence s_fmt_write;
		bus_req.wr && (bus_req.addr == ACF_IDX_FMT);
	endsequence

	a_rd_idle_zero: assert property (
		!bus_req.rd |=> rd_data == 8'h00)
		else $error("read data not zero outside a read");

	a_hi_readback: assert property (
		s_hi_read |=> rd_data == $past(res_hi_r))
		else $error("result high read wrong");

	a_lo_readback: assert property (
		s_lo_read |=> rd_data == $past(res_lo_r))
		else $error("result low read wrong");

	a_fmt_readback: assert property (
		s_fmt_read |=> rd_data
			== {6'h00, $past(clk_sel_r[1:0] == ACF_RC_CODE), $past(fmt_r)})
		else $error("format register read wrong");

	a_fmt_take: assert property (
		s_fmt_write |=> fmt_r == $past(bus_req.wdata[0]))
		else $error("format write not taken");

	a_hi_sw_write: assert property (
		(bus_req.wr && bus_req.addr == ACF_IDX_RES_HI && !conv_done)
			|=> res_hi_r == $past(bus_req.wdata))
		else $error("result high write not taken");

	a_lo_sw_write: assert property (
		(bus_req.wr && bus_req.addr == ACF_IDX_RES_LO && !conv_done)
			|=> res_lo_r == $past(bus_req.wdata))
		else $error("result low write not taken");

	// Idle cycles leave the stored values alone
	a_res_hold: assert property (
		(!rst && !conv_done && !bus_req.wr)
			|=> $stable(res_hi_r) && $stable(res_lo_r))
		else $error("result registers changed without cause");

	a_sel_hold: assert property (
		(!rst && !(bus_req.wr && bus_req.addr == ACF_IDX_CLK_SEL))
			|=> $stable(clk_sel_r))
		else $error("clock select changed without a write");

	// Settled pulses are one core cycle wide
	a_tick_one_cycle: assert property (
		(conv_tick && seen_r == 2'h3) |=> !conv_tick)
		else $error("conversion tick longer than one cycle");

	a_left_low_rsv: assert property (
		s_done_left |=> res_lo_r[5:0] == 6'h00)
		else $error("left justified low reserved bits not zero");

	a_right_high_rsv: assert property (
		s_done_right |=> res_hi_r[7:2] == 6'h00)
		else $error("right justified high reserved bits not zero");

endmodule

// *** verification/tb.sv ***
`timescale 1ns/1ns
module tb;
	import acf_pkg::*;

	// ==========================================================
	// Design signals and counters
	logic core_clk;
	logic rst;
	acf_bus_req_t bus_req;
	logic [7:0] rd_data;
	logic conv_done;
	logic [9:0] conv_result;
	logic conv_tick;
	int mismatches;
	int comparisons;
	int n;
	// Tick period per select code, index is the code
	int per [8] = '{2, 8, 32, 20, 4, 16, 64, 20};
	logic [9:0] vals [4] = '{10'h3FF, 10'h001, 10'h2D7, 10'h128};

	acf_adc_clk_fmt uut (
		.core_clk(core_clk),
		.rst(rst),
		.bus_req(bus_req),
		.rd_data(rd_data),
		.conv_done(conv_done),
		.conv_result(conv_result),
		.conv_tick(conv_tick)
	);

	// Core clock, 100 ns period
	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end

	// ==========================================================
	// Checks and bus tasks
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic test_done();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
		@(posedge core_clk);
		bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge core_clk);
		bus_req.wr <= 1'b0;
	endtask

	// Read, mask off bits software must ignore, compare
	task automatic rd_chk(input logic [1:0] a, input logic [7:0] m, input logic [7:0] e);
		@(posedge core_clk);
		bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge core_clk);
		bus_req.rd <= 1'b0;
		#1;
		chk(rd_data & m, e);
	endtask

	// Completion pulse, optionally with a same-cycle write to result high
	task automatic conv(input logic [9:0] r, input logic sw);
		@(posedge core_clk);
		conv_done <= 1'b1;
		conv_result <= r;
		if (sw) begin
			bus_req <= '{addr: ACF_IDX_RES_HI, wdata: 8'h5A, wr: 1'b1, rd: 1'b0};
		end
		@(posedge core_clk);
		conv_done <= 1'b0;
		bus_req.wr <= 1'b0;
	endtask

	// Cycles until the next tick, bounded
	task automatic wait_tick(output int k);
		k = 0;
		do begin
			@(posedge core_clk);
			#1;
			k++;
			if (k > 200) begin
				mismatches++;
				$display("timeout waiting for conversion tick");
				test_done();
			end
		end while (conv_tick !== 1'b1);
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		rst = 1'b1;
		bus_req = '0;
		conv_done = 1'b0;
		conv_result = 10'h000;
		mismatches = 0;
		comparisons = 0;
		repeat (12) @(posedge core_clk);
		rst <= 1'b0;
		// Reset values of all registers
		rd_chk(ACF_IDX_CLK_SEL, 8'hFF, 8'h00);
		rd_chk(ACF_IDX_RES_HI, 8'hFF, ACF_RES_RST);
		rd_chk(ACF_IDX_RES_LO, 8'hFF, ACF_RES_RST);
		rd_chk(ACF_IDX_FMT, 8'hFF, 8'h00);
		// Unimplemented select bits read zero
		wr_reg(ACF_IDX_CLK_SEL, 8'hFF);
		rd_chk(ACF_IDX_CLK_SEL, 8'hFF, 8'h70);
		wr_reg(ACF_IDX_CLK_SEL, 8'h8F);
		rd_chk(ACF_IDX_CLK_SEL, 8'hFF, 8'h00);
		// Every select code gives its tick period; codes 3 and 7 both give the RC one
		for (int c = 0; c < 8; c++) begin
			wr_reg(ACF_IDX_CLK_SEL, {1'b0, 3'(c), 4'h0});
			rd_chk(ACF_IDX_FMT, 8'h02, {6'h00, c[1:0] == 2'h3, 1'b0});
			wait_tick(n);
			wait_tick(n);
			wait_tick(n);
			chk(8'(n), 8'(per[c]));
		end
		// Both layouts for several results
		foreach (vals[i]) begin
			for (int f = 0; f < 2; f++) begin
				wr_reg(ACF_IDX_FMT, 8'(f));
				conv(vals[i], 1'b0);
				if (f == 0) begin
					rd_chk(ACF_IDX_RES_HI, 8'hFF, vals[i][9:2]);
					rd_chk(ACF_IDX_RES_LO, 8'hC0, {vals[i][1:0], 6'h00});
				end else begin
					rd_chk(ACF_IDX_RES_HI, 8'h03, {6'h00, vals[i][9:8]});
					rd_chk(ACF_IDX_RES_LO, 8'hFF, vals[i][7:0]);
				end
			end
		end
		// Layout stays as taken at completion
		wr_reg(ACF_IDX_FMT, 8'h00);
		rd_chk(ACF_IDX_RES_HI, 8'h03, 8'h01);
		rd_chk(ACF_IDX_RES_LO, 8'hFF, 8'h28);
		// Software write, then conversion beating a same-cycle write
		wr_reg(ACF_IDX_RES_HI, 8'hA5);
		rd_chk(ACF_IDX_RES_HI, 8'hFF, 8'hA5);
		conv(10'h2AA, 1'b1);
		rd_chk(ACF_IDX_RES_HI, 8'hFF, 8'hAA);
		rd_chk(ACF_IDX_RES_LO, 8'hC0, 8'h80);
		// Reset again in mid-run
		@(posedge core_clk);
		rst <= 1'b1;
		@(posedge core_clk);
		rst <= 1'b0;
		rd_chk(ACF_IDX_CLK_SEL, 8'hFF, 8'h00);
		rd_chk(ACF_IDX_RES_HI, 8'hFF, ACF_RES_RST);
		test_done();
	end
endmodule
